/* pkg/ctc_pkg.sv */
// Constants and types shared by the current threshold comparator files.
package ctc_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte addresses.
  localparam logic [31:0] ADDR_THRESH = 32'hFFFF0550;
  localparam logic [31:0] ADDR_LIMIT = 32'hFFFF0554;
  localparam logic [31:0] ADDR_COUNT = 32'hFFFF0558;
  localparam logic [31:0] ADDR_CONFIG = 32'hFFFF0560;
  localparam logic [31:0] ADDR_STATUS = 32'hFFFF0564;
  localparam logic [31:0] ADDR_CLEAR = 32'hFFFF0568;
  localparam logic [31:0] ADDR_IRQ_EN = 32'hFFFF056C;

  //////////////////////////////////////////////////////////////////////////////
  // Field widths.
  localparam int THRESH_W = 16;
  localparam int COUNT_W = 8;
  localparam int CFG_W = 3;
  localparam int STAT_W = 3;

  // Configuration bits.
  localparam int CFG_EN_BIT = 0;
  localparam int CFG_CLR_BIT = 1;
  localparam int CFG_TWOS_BIT = 2;

  // Status, clear and interrupt enable bits share one layout.
  localparam int ST_HIT_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_SAT_BIT = 2;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values.
  localparam logic [15:0] THRESH_RST = 16'h0000;
  localparam logic [7:0] LIMIT_RST = 8'h01;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [2:0] CFG_RST = 3'h0;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] IRQ_EN_RST = 3'h0;

  // Counter end stops.
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [7:0] COUNT_MIN = 8'h00;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic HRESP_OKAY = 1'b0;

  // Register selected by an address.
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_THRESH,
    SEL_LIMIT,
    SEL_COUNT,
    SEL_CONFIG,
    SEL_STATUS,
    SEL_CLEAR,
    SEL_IRQ_EN
  } reg_sel_t;

endpackage

/* logic/magnitude_compare.sv */
// Magnitude of a conversion result compared against the threshold.
`timescale 1ns/100ps
`default_nettype none

module magnitude_compare (
  // Operands
  input wire logic [15:0] result,
  input wire logic [15:0] thresh,
  input wire logic twos_mode,
  // Outcome
  output logic at_or_above
);

  logic [15:0] magnitude;
  logic [15:0] limit_value;

  always_comb begin
    // The most negative code has magnitude 0x8000, which still fits.
    if (twos_mode && result[15]) begin
      magnitude = 16'(~result + 16'h0001);
    end else begin
      magnitude = result;
    end
    if (twos_mode) begin
      limit_value = {1'b0, thresh[14:0]};
    end else begin
      limit_value = thresh;
    end
    at_or_above = (magnitude >= limit_value);
  end

endmodule // magnitude_compare

`default_nettype wire

/* logic/threshold_counter.sv */
// Up and down counter of over-threshold results with limit detection.
`timescale 1ns/100ps
`default_nettype none

module threshold_counter (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Control
  input wire logic clear,
  input wire logic step,
  input wire logic at_or_above,
  input wire logic clear_below,
  input wire logic [7:0] limit,
  // State and events
  output logic [7:0] count,
  output logic hit,
  output logic saturated
);

  typedef struct packed {
    logic [7:0] count;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    hit = 1'b0;
    saturated = 1'b0;
    if (clear) begin
      s_d.count = ctc_pkg::COUNT_RST;
    end else if (step) begin
      if (at_or_above) begin
        if (s_q.count == ctc_pkg::COUNT_MAX) begin
          saturated = 1'b1;
        end else begin
          s_d.count = s_q.count + 8'h01;
        end
      end else if (clear_below) begin
        s_d.count = ctc_pkg::COUNT_MIN;
      end else if (s_q.count != ctc_pkg::COUNT_MIN) begin
        s_d.count = s_q.count - 8'h01;
      end
      // The flag fires in the same edge that makes the count equal.
      hit = (s_d.count == limit);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.count <= ctc_pkg::COUNT_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.count;

endmodule // threshold_counter

`default_nettype wire

/* logic/current_threshold_comparator.sv */
// Current channel threshold comparator with its AHB-Lite register file.
`timescale 1ns/100ps
`default_nettype none

module current_threshold_comparator (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Current channel conversion results
  input wire logic result_valid,
  input wire logic [15:0] result_data,
  // Interrupt
  output logic adc_irq
);

  //////////////////////////////////////////////////////////////////////////////
  // State.

  typedef struct packed {
    logic [15:0] thresh;
    logic [7:0] limit;
    logic [2:0] cfg;
    logic [2:0] status;
    logic [2:0] irq_en;
    logic wr_pend;
    ctc_pkg::reg_sel_t wr_sel;
    logic [31:0] rdata;
    logic ready;
    logic resp;
    logic irq;
    logic res_valid;
    logic [15:0] res_data;
  } main_state_t;

  main_state_t s_q;
  main_state_t s_d;

  logic [7:0] count;
  logic hit;
  logic saturated;
  logic at_or_above;
  logic step;
  logic enabled;
  logic take;
  logic [2:0] events;
  logic [2:0] clear_bits;
  ctc_pkg::reg_sel_t addr_sel;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode and read mux.

  // Only full-word aligned addresses of this block map to a register.
  function automatic ctc_pkg::reg_sel_t decode(input logic [31:0] a);
    ctc_pkg::reg_sel_t sel;
    sel = ctc_pkg::SEL_NONE;
    unique case (a)
      ctc_pkg::ADDR_THRESH: sel = ctc_pkg::SEL_THRESH;
      ctc_pkg::ADDR_LIMIT: sel = ctc_pkg::SEL_LIMIT;
      ctc_pkg::ADDR_COUNT: sel = ctc_pkg::SEL_COUNT;
      ctc_pkg::ADDR_CONFIG: sel = ctc_pkg::SEL_CONFIG;
      ctc_pkg::ADDR_STATUS: sel = ctc_pkg::SEL_STATUS;
      ctc_pkg::ADDR_CLEAR: sel = ctc_pkg::SEL_CLEAR;
      ctc_pkg::ADDR_IRQ_EN: sel = ctc_pkg::SEL_IRQ_EN;
      default: sel = ctc_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction

  // Read data comes from the next-state copy so that a read right after
  // a write returns the freshly written value.
  function automatic logic [31:0] read_word(
    input ctc_pkg::reg_sel_t sel,
    input main_state_t s,
    input logic [7:0] cnt
  );
    logic [31:0] w;
    w = 32'h00000000;
    unique case (sel)
      ctc_pkg::SEL_THRESH: w = {16'h0000, s.thresh};
      ctc_pkg::SEL_LIMIT: w = {24'h000000, s.limit};
      ctc_pkg::SEL_COUNT: w = {24'h000000, cnt};
      ctc_pkg::SEL_CONFIG: w = {29'h00000000, s.cfg};
      ctc_pkg::SEL_STATUS: w = {29'h00000000, s.status};
      ctc_pkg::SEL_IRQ_EN: w = {29'h00000000, s.irq_en};
      ctc_pkg::SEL_CLEAR: w = 32'h00000000;
      ctc_pkg::SEL_NONE: w = 32'h00000000;
    endcase
    return w;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Comparison and counting.

  assign enabled = s_q.cfg[ctc_pkg::CFG_EN_BIT];
  // The captured result is processed one cycle after its strobe.
  assign step = s_q.res_valid & enabled;

  magnitude_compare u_compare (
    .result(s_q.res_data),
    .thresh(s_q.thresh),
    .twos_mode(s_q.cfg[ctc_pkg::CFG_TWOS_BIT]),
    .at_or_above(at_or_above)
  );

  // A disabled comparator holds its count at zero.
  threshold_counter u_counter (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(~enabled),
    .step(step),
    .at_or_above(at_or_above),
    .clear_below(s_q.cfg[ctc_pkg::CFG_CLR_BIT]),
    .limit(s_q.limit),
    .count(count),
    .hit(hit),
    .saturated(saturated)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state.

  assign take = hsel & hready & (htrans == ctc_pkg::HTRANS_NONSEQ);
  assign addr_sel = decode(haddr);

  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b1;
    s_d.resp = ctc_pkg::HRESP_OKAY;

    // Capture stage for the incoming result.
    s_d.res_valid = result_valid & enabled;
    if (result_valid) begin
      s_d.res_data = result_data;
    end

    events = 3'h0;
    events[ctc_pkg::ST_HIT_BIT] = hit;
    events[ctc_pkg::ST_DONE_BIT] = step;
    events[ctc_pkg::ST_SAT_BIT] = saturated;

    // Data phase of a write.
    clear_bits = 3'h0;
    if (s_q.wr_pend) begin
      unique case (s_q.wr_sel)
        ctc_pkg::SEL_THRESH: s_d.thresh = hwdata[15:0];
        ctc_pkg::SEL_LIMIT: s_d.limit = hwdata[7:0];
        ctc_pkg::SEL_CONFIG: s_d.cfg = hwdata[2:0];
        ctc_pkg::SEL_CLEAR: clear_bits = hwdata[2:0];
        ctc_pkg::SEL_IRQ_EN: s_d.irq_en = hwdata[2:0];
        ctc_pkg::SEL_COUNT: ;
        ctc_pkg::SEL_STATUS: ;
        ctc_pkg::SEL_NONE: ;
      endcase
    end

    // An event in the clearing cycle survives the clear.
    s_d.status = (s_q.status & ~clear_bits) | events;
    s_d.irq = |(s_d.status & s_d.irq_en);

    // Address phase.
    s_d.wr_pend = take & hwrite;
    s_d.wr_sel = take ? addr_sel : ctc_pkg::SEL_NONE;
    if (take && !hwrite) begin
      s_d.rdata = read_word(addr_sel, s_d, count);
    end else begin
      s_d.rdata = 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q.thresh <= ctc_pkg::THRESH_RST;
      s_q.limit <= ctc_pkg::LIMIT_RST;
      s_q.cfg <= ctc_pkg::CFG_RST;
      s_q.status <= ctc_pkg::STAT_RST;
      s_q.irq_en <= ctc_pkg::IRQ_EN_RST;
      s_q.wr_pend <= 1'b0;
      s_q.wr_sel <= ctc_pkg::SEL_NONE;
      s_q.rdata <= 32'h00000000;
      s_q.ready <= 1'b1;
      s_q.resp <= ctc_pkg::HRESP_OKAY;
      s_q.irq <= 1'b0;
      s_q.res_valid <= 1'b0;
      s_q.res_data <= 16'h0000;
    end else begin
      s_q <= s_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign hreadyout = s_q.ready;
  assign hresp = s_q.resp;
  assign hrdata = s_q.rdata;
  assign adc_irq = s_q.irq;

endmodule // current_threshold_comparator

`default_nettype wire

/* tb/ctc_monitor.sv */
// Port checker for the current threshold comparator.
`timescale 1ns/100ps
`default_nettype none

module ctc_monitor (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Results and interrupt
  input wire logic result_valid,
  input wire logic adc_irq
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  logic ph_q, wr_q, en_q;
  logic [31:0] a_q;
  logic [1:0] dis_q;
  wire rd = ph_q && !wr_q;
  wire wr_en = ph_q && wr_q && a_q == ctc_pkg::ADDR_IRQ_EN;
  wire wr_clr = ph_q && wr_q && a_q == ctc_pkg::ADDR_CLEAR;
  // Follows the data phase, the enable bit and the cycles since disable.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_q <= 1'b0;
      wr_q <= 1'b0;
      a_q <= 32'h0;
      en_q <= 1'b0;
      dis_q <= 2'h3;
    end else begin
      ph_q <= hsel && hready && htrans == ctc_pkg::HTRANS_NONSEQ;
      wr_q <= hwrite;
      a_q <= haddr;
      if (ph_q && wr_q && a_q == ctc_pkg::ADDR_CONFIG) begin
        en_q <= hwdata[0];
      end
      dis_q <= en_q ? 2'h0 : dis_q + {1'b0, dis_q != 2'h3};
    end
  end
  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
  idle_zero_a: assert property (!rd |-> hrdata == 32'h0)
    else $error("read data outside a read data phase");
  irq_rise_a: assert property ($rose(adc_irq) |->
    $past(result_valid, 2) || $past(wr_en, 1))
    else $error("interrupt rose without a cause");
  irq_fall_a: assert property ($fell(adc_irq) |->
    $past(wr_clr, 1) || $past(wr_en, 1))
    else $error("interrupt fell without a clear");
  limit_width_a: assert property (rd && a_q == ctc_pkg::ADDR_LIMIT
    |-> hrdata[31:8] == 24'h0) else $error("limit wider than 8 bits");
  count_width_a: assert property (rd && a_q == ctc_pkg::ADDR_COUNT
    |-> hrdata[31:8] == 24'h0) else $error("count wider than 8 bits");
  irq_status_a: assert property (adc_irq && rd
    && a_q == ctc_pkg::ADDR_STATUS |-> hrdata[2:0] != 3'h0)
    else $error("interrupt high with empty status");
  off_count_a: assert property (rd && dis_q == 2'h3
    && a_q == ctc_pkg::ADDR_COUNT |-> hrdata == 32'h0)
    else $error("count not zero while disabled");
  cover property ($rose(adc_irq));
  cover property (result_valid [*2]);
  cover property (rd && dis_q == 2'h3 && a_q == ctc_pkg::ADDR_COUNT);
endmodule // ctc_monitor

bind current_threshold_comparator ctc_monitor ctc_monitor_i (.hclk,
  .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hreadyout, .hresp, .hrdata, .result_valid, .adc_irq);

`default_nettype wire

/* tb/adc_source.sv */
// Model of the current channel result path feeding the comparator.
`timescale 1ns/100ps
`default_nettype none

module adc_source (
  // Clock
  input wire logic hclk,
  // Result strobe
  output logic result_valid,
  output logic [15:0] result_data
);
  initial begin
    result_valid = 1'b0;
    result_data = 16'h0000;
  end
  // Data is inverted between results so that no stale value looks valid.
  task automatic send(input logic [15:0] d, input int gap);
    if (gap > 0) begin
      result_valid <= 1'b0;
      result_data <= ~result_data;
      repeat (gap) @(posedge hclk);
    end
    result_valid <= 1'b1;
    result_data <= d;
    @(posedge hclk);
  endtask
  task automatic stop();
    result_valid <= 1'b0;
    result_data <= ~result_data;
  endtask
endmodule // adc_source

`default_nettype wire

/* tb/current_threshold_comparator_bench.sv */
// Self-checking bench for the current threshold comparator.
`timescale 1ns/100ps
`default_nettype none

module current_threshold_comparator_bench;
  logic hclk, hresetn, hwrite, hreadyout, hresp, result_valid, adc_irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [15:0] result_data;
  int n_mismatch = 0;
  int n_tests = 0;
  int cyc = 0;

  current_threshold_comparator current_threshold_comparator_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .result_valid(result_valid),
    .result_data(result_data), .adc_irq(adc_irq));
  adc_source adc_source_i (.hclk(hclk), .result_valid(result_valid),
    .result_data(result_data));

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    forever begin
      @(posedge hclk);
      cyc++;
      if (cyc == 3000) begin
        n_mismatch++;
        final_report();
      end
    end
  end

  //////////////////////////////////////////
  task automatic chk(input logic [31:0] id, s, e);
    n_tests++;
    if (s !== e) begin
      n_mismatch++;
      $display("mismatch %h expected %h seen %h", id, e, s);
    end
  endtask
  task automatic wait_rdy();
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [31:0] a, d);
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= ctc_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rc(input logic [31:0] a, e);
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= ctc_pkg::HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    chk(a, hrdata, e);
  endtask
  task automatic irq(input logic e);
    chk(32'h1, {31'h0, adc_irq}, {31'h0, e});
  endtask
  task automatic put(input logic [15:0] d);
    adc_source_i.send(d, 0);
  endtask
  task automatic fin();
    adc_source_i.stop();
    repeat (2) @(posedge hclk);
  endtask

  //////////////////////////////////////////
  task automatic t_reset();
    rc(ctc_pkg::ADDR_THRESH, 32'h0);
    rc(ctc_pkg::ADDR_LIMIT, 32'h1);
    rc(ctc_pkg::ADDR_COUNT, 32'h0);
    wr(32'hFFFF0570, 32'hFFFFFFFF);
    rc(32'hFFFF0570, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_count();
    wr(ctc_pkg::ADDR_THRESH, 32'hFFFF0100);
    rc(ctc_pkg::ADDR_THRESH, 32'h100);
    wr(ctc_pkg::ADDR_LIMIT, 32'h3);
    wr(ctc_pkg::ADDR_CONFIG, 32'h1);
    put(16'h0100);
    put(16'h0100);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h2);
    adc_source_i.send(16'h00FF, 3);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h1);
    put(16'hFFFF);
    put(16'h0200);
    fin();
    rc(ctc_pkg::ADDR_STATUS, 32'h3);
    irq(1'b0);
    wr(ctc_pkg::ADDR_COUNT, 32'h0);
    rc(ctc_pkg::ADDR_COUNT, 32'h3);
    wr(ctc_pkg::ADDR_IRQ_EN, 32'h1);
    irq(1'b0);
    rc(ctc_pkg::ADDR_STATUS, 32'h3);
    irq(1'b1);
    wr(ctc_pkg::ADDR_CLEAR, 32'h7);
    rc(ctc_pkg::ADDR_STATUS, 32'h0);
    irq(1'b0);
    $display("counting done");
  endtask
  task automatic t_modes();
    wr(ctc_pkg::ADDR_CONFIG, 32'h3);
    put(16'h0200);
    put(16'h0000);
    put(16'h0200);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h1);
    wr(ctc_pkg::ADDR_CONFIG, 32'h0);
    put(16'h0300);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h0);
    wr(ctc_pkg::ADDR_THRESH, 32'h8100);
    wr(ctc_pkg::ADDR_CONFIG, 32'h5);
    put(16'hFF00);
    put(16'h0100);
    put(16'hFF01);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h1);
    wr(ctc_pkg::ADDR_CONFIG, 32'h1);
    put(16'h8100);
    put(16'h80FF);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h1);
    $display("modes done");
  endtask
  // Drives the count into its top end stop, then checks the bottom one.
  task automatic t_limits();
    wr(ctc_pkg::ADDR_LIMIT, 32'hFF);
    wr(ctc_pkg::ADDR_CLEAR, 32'h7);
    rc(ctc_pkg::ADDR_COUNT, 32'h1);
    repeat (256) put(16'h8100);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'hFF);
    rc(ctc_pkg::ADDR_STATUS, 32'h7);
    irq(1'b1);
    wr(ctc_pkg::ADDR_CONFIG, 32'h0);
    wr(ctc_pkg::ADDR_CONFIG, 32'h1);
    put(16'h0000);
    fin();
    rc(ctc_pkg::ADDR_COUNT, 32'h0);
    $display("limits done");
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    hresetn = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_count();
    t_modes();
    t_limits();
    final_report();
  end
endmodule // current_threshold_comparator_bench

`default_nettype wire
